// >>> core/thb_regs.svh
// Constants of the triple half-bridge serial control block.
// Assumes a 100 MHz system clock; included by bare name with the package.
`ifndef THB_REGS_SVH
`define THB_REGS_SVH

// Serial word length and field widths.
`define THB_WORD_BITS      16
`define THB_SWITCH_BITS    6
`define THB_UNUSED_IN_BITS 6
`define THB_ZERO_OUT_BITS  5
`define THB_CHANNELS       3

// Field positions inside the serial words.
`define THB_CLEAR_BIT      0
`define THB_SWITCH_LSB     1
`define THB_LOCKOUT_BIT    15
`define THB_SUPPLY_BIT     15

// Reset values of the command word and the status snapshot.
`define THB_CMD_RESET      16'h0000
`define THB_STATUS_RESET   16'h0000

// Timing figures in their own units.
`define THB_CLK_MHZ        100
`define THB_FILTER_US      10
`define THB_OC_LONG_US     200
`define THB_OC_SHORT_US    25
`define THB_CS_HIGH_NS     5000

`endif

// >>> core/thb_pkg.sv
// Types shared by the triple half-bridge serial control block.
// Assumes thb_regs.svh supplies the field widths.
`include "thb_regs.svh"

package thb_pkg;

  // Six switch commands or states, low side 1 in the lowest bit.
  typedef struct packed {
    logic high_side_3_on;
    logic low_side_3_on;
    logic high_side_2_on;
    logic low_side_2_on;
    logic high_side_1_on;
    logic low_side_1_on;
  } thb_switch_type;

  // Command word as received, bit 15 first in this list.
  typedef struct packed {
    logic                            overvoltage_lockout_enable;
    logic                            underload_shutdown_enable;
    logic                            overcurrent_delay_select;
    logic [`THB_UNUSED_IN_BITS-1:0]  unused;
    thb_switch_type                  switches;
    logic                            status_clear_request;
  } thb_cmd_type;

  // Status word as sent back, bit 15 first in this list.
  typedef struct packed {
    logic                            supply_fail_flag;
    logic                            underload_flag;
    logic                            overcurrent_flag;
    logic                            shoot_through_flag;
    logic [`THB_ZERO_OUT_BITS-1:0]   zero;
    thb_switch_type                  switches;
    logic                            thermal_warning_flag;
  } thb_status_type;

  // Conditions reported by the analog monitors.
  typedef struct packed {
    logic                            supply_over;
    logic                            supply_under;
    logic [`THB_SWITCH_BITS-1:0]     underload;
    logic [`THB_SWITCH_BITS-1:0]     overcurrent;
    logic                            thermal_warning;
  } thb_sense_type;

  // Fault filter sequencer, one-hot.
  typedef enum logic [1:0] {
    THB_FLT_IDLE = 2'b01,
    THB_FLT_HOLD = 2'b10
  } thb_filter_state_type;

endpackage

// >>> core/thb_spi_ctrl.sv
// Serial control and fault reporting of a triple half-bridge driver.
// Assumes sclk stands low outside frames and the monitors give plain levels.
//
// Notes on behaviour
// - Sixteen-bit word sets switches, returns faults.
// - Least significant bit shifted first both ways.
// - Chip-select rise latches the shifted command word.
// - Serial output floats while chip-select is high.
// - Accept only multiples of sixteen clocks.
// - Count rising clocks from chip-select fall.
// - Valid frame with bit zero clears faults; refilter before relatch.
// - Status shifts out while command shifts in.
// - Bits one to six command the switches.
// - Bit fifteen enables overvoltage output lockout.
// - Bit fourteen enables underload latch-off.
// - Bit thirteen selects overcurrent shutdown delay.
// - Bit zero clears latched fault flags.
// - Status word layout, one means fault.
// - Overvoltage always sets supply-fail flag.
// - Lockout forces all outputs off meanwhile.
// - Commands kept; outputs resume after overvoltage.
// - Supply-fail stays until a clear request.
// - Drivers off at start and undervoltage.
// - Serial port works whatever the driver supply.
// - Open chip-select means deselected.
`timescale 1ns/1ps
`include "thb_regs.svh"

module thb_spi_ctrl
  import thb_pkg::*;
#(
  parameter int unsigned OC_LONG_CYCLES  = `THB_OC_LONG_US * `THB_CLK_MHZ,
  parameter int unsigned OC_SHORT_CYCLES = `THB_OC_SHORT_US * `THB_CLK_MHZ
) (
  input  wire logic           mclk,
  input  wire logic           srst,
  input  wire logic           sclk,
  input  wire logic           chip_select_n,
  input  wire logic           serial_in,
  output logic                serial_out,
  output logic                serial_out_oe,
  input  wire thb_sense_type  sense,
  output thb_switch_type      drivers,
  output logic                underload_shutdown_enable,
  output logic                overcurrent_delay_select,
  output logic [14:0]         oc_delay_cycles
);

  // Fault filter length in system clock cycles, at least one.
  localparam int FILTER_RAW    = `THB_FILTER_US * `THB_CLK_MHZ;
  localparam int FILTER_CYCLES = (FILTER_RAW < 1) ? 1 : FILTER_RAW;

  logic                        link_set;
  logic                        fresh;
  logic [`THB_WORD_BITS-1:0]   shift_word;
  logic [3:0]                  bit_count;
  logic                        frame_tog;
  logic [`THB_WORD_BITS-1:0]   status_hold;
  logic                        cs_meta;
  logic                        cs_sync;
  logic                        cs_last;
  logic                        cs_rise;
  logic                        tog_meta;
  logic                        tog_sync;
  logic                        tog_seen;
  logic                        frame_ok;
  thb_cmd_type                 rx_word;
  thb_cmd_type                 cmd;
  logic                        clear_now;
  thb_sense_type               sense_meta;
  thb_sense_type               sense_sync;
  thb_filter_state_type        filt_state;
  logic [15:0]                 filt_count;
  logic                        set_ok;
  logic                        supply_fail_flag;
  logic                        underload_flag;
  logic                        overcurrent_flag;
  logic                        shoot_through_flag;
  logic                        thermal_warning_flag;
  logic [`THB_SWITCH_BITS-1:0] uld_latch;
  logic [`THB_SWITCH_BITS-1:0] pair_block;
  logic [`THB_CHANNELS-1:0]    rx_conflict;
  logic [`THB_SWITCH_BITS-1:0] next_drive;
  thb_status_type              status_now;

  // ---------------- Link domain, clocked by sclk ----------------

  // Chip-select high or reset marks the next clock as the first of a frame.
  assign link_set = chip_select_n | srst;

  // The first-edge marker is preset while the device is deselected.
  always_ff @(posedge sclk or posedge link_set) begin
    if (link_set) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // One register loads the status and shifts command bits in at the top.
  always_ff @(posedge sclk or posedge srst) begin
    if (srst) begin
      shift_word <= `THB_CMD_RESET;
    end else if (!chip_select_n) begin
      if (fresh) begin
        shift_word <= {serial_in, status_hold[`THB_WORD_BITS-1:1]};
      end else begin
        shift_word <= {serial_in, shift_word[`THB_WORD_BITS-1:1]};
      end
    end
  end

  // Frame length modulo sixteen, restarted on the first edge.
  always_ff @(posedge sclk or posedge srst) begin
    if (srst) begin
      bit_count <= 4'h0;
    end else if (!chip_select_n) begin
      if (fresh) begin
        bit_count <= 4'h1;
      end else begin
        bit_count <= bit_count + 4'h1;
      end
    end
  end

  // A toggle per frame tells the system side that clocks arrived at all.
  always_ff @(posedge sclk or posedge srst) begin
    if (srst) begin
      frame_tog <= 1'b0;
    end else if (!chip_select_n && fresh) begin
      frame_tog <= ~frame_tog;
    end
  end

  // Serial output: snapshot bit 0 before the first edge, then the shifter.
  assign serial_out    = fresh ? status_hold[0] : shift_word[0];
  assign serial_out_oe = ~chip_select_n;

  // ---------------- System domain, clocked by mclk ----------------

  // Chip-select crosses through two flip-flops; a third finds the rise.
  always_ff @(posedge mclk) begin
    if (srst) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_last <= 1'b1;
    end else begin
      cs_meta <= chip_select_n;
      cs_sync <= cs_meta;
      cs_last <= cs_sync;
    end
  end

  assign cs_rise = cs_sync & ~cs_last;

  // The frame toggle crosses through two flip-flops as an event.
  always_ff @(posedge mclk) begin
    if (srst) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_seen <= 1'b0;
    end else begin
      tog_meta <= frame_tog;
      tog_sync <= tog_meta;
      if (cs_rise) begin
        tog_seen <= tog_sync;
      end
    end
  end

  // Shifter and count stand still once the clock rests low and the
  // device is deselected, so they are read whole after the rise.
  assign rx_word  = thb_cmd_type'(shift_word);
  assign frame_ok = cs_rise && (tog_sync != tog_seen) && (bit_count == 4'h0);
  assign clear_now = frame_ok & rx_word.status_clear_request;

  // The command word is latched on a valid frame; unused bits are dropped.
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmd <= thb_cmd_type'(`THB_CMD_RESET);
    end else if (frame_ok) begin
      cmd        <= rx_word;
      cmd.unused <= '0;
    end
  end

  // Options handed to the current monitors.
  always_ff @(posedge mclk) begin
    if (srst) begin
      underload_shutdown_enable <= 1'b0;
      overcurrent_delay_select  <= 1'b0;
      oc_delay_cycles           <= 15'(OC_LONG_CYCLES);
    end else begin
      underload_shutdown_enable <= cmd.underload_shutdown_enable;
      overcurrent_delay_select  <= cmd.overcurrent_delay_select;
      oc_delay_cycles           <= cmd.overcurrent_delay_select ?
                                   15'(OC_SHORT_CYCLES) : 15'(OC_LONG_CYCLES);
    end
  end

  // Monitor levels come from outside this clock and pass two flip-flops.
  always_ff @(posedge mclk) begin
    if (srst) begin
      sense_meta <= '0;
      sense_sync <= '0;
    end else begin
      sense_meta <= sense;
      sense_sync <= sense_meta;
    end
  end

  // After a valid frame, present faults may latch again only after the filter.
  always_ff @(posedge mclk) begin
    if (srst) begin
      filt_state <= THB_FLT_IDLE;
      filt_count <= 16'h0000;
    end else begin
      case (filt_state)
        THB_FLT_IDLE: begin
          if (frame_ok) begin
            filt_state <= THB_FLT_HOLD;
            filt_count <= 16'(FILTER_CYCLES - 1);
          end
        end
        THB_FLT_HOLD: begin
          if (frame_ok) begin
            filt_count <= 16'(FILTER_CYCLES - 1);
          end else if (filt_count == 16'h0000) begin
            filt_state <= THB_FLT_IDLE;
          end else begin
            filt_count <= filt_count - 16'h0001;
          end
        end
        default: begin
          filt_state <= THB_FLT_IDLE;
          filt_count <= 16'h0000;
        end
      endcase
    end
  end

  assign set_ok = (filt_state == THB_FLT_IDLE) && !frame_ok;

  // Latched fault flags; no fault sets in the cycle of a valid frame, so a clear wins.
  always_ff @(posedge mclk) begin
    if (srst) begin
      supply_fail_flag     <= 1'b0;
      underload_flag       <= 1'b0;
      overcurrent_flag     <= 1'b0;
      thermal_warning_flag <= 1'b0;
    end else begin
      if (set_ok && (sense_sync.supply_over || sense_sync.supply_under)) begin
        supply_fail_flag <= 1'b1;
      end else if (clear_now) begin
        supply_fail_flag <= 1'b0;
      end
      if (set_ok && (|sense_sync.underload)) begin
        underload_flag <= 1'b1;
      end else if (clear_now) begin
        underload_flag <= 1'b0;
      end
      if (set_ok && (|sense_sync.overcurrent)) begin
        overcurrent_flag <= 1'b1;
      end else if (clear_now) begin
        overcurrent_flag <= 1'b0;
      end
      if (set_ok && sense_sync.thermal_warning) begin
        thermal_warning_flag <= 1'b1;
      end else if (clear_now) begin
        thermal_warning_flag <= 1'b0;
      end
    end
  end

  // Per channel: conflict in the received word and the pair block.
  genvar ch;
  generate
    for (ch = 0; ch < `THB_CHANNELS; ch++) begin : g_pair
      assign rx_conflict[ch]      = rx_word.switches[2*ch] & rx_word.switches[2*ch+1];
      assign pair_block[2*ch]     = (cmd.switches[2*ch] & cmd.switches[2*ch+1])
                                    | shoot_through_flag;
      assign pair_block[2*ch+1]   = pair_block[2*ch];
    end
  endgenerate

  // A command turning both sides of a channel on is recorded and refused.
  always_ff @(posedge mclk) begin
    if (srst) begin
      shoot_through_flag <= 1'b0;
    end else if (frame_ok && (|rx_conflict)) begin
      shoot_through_flag <= 1'b1;
    end else if (clear_now) begin
      shoot_through_flag <= 1'b0;
    end
  end

  // Per driver: underload latch-off and the gated drive level.
  genvar sw;
  generate
    for (sw = 0; sw < `THB_SWITCH_BITS; sw++) begin : g_drv
      always_ff @(posedge mclk) begin
        if (srst) begin
          uld_latch[sw] <= 1'b0;
        end else if (set_ok && sense_sync.underload[sw] &&
                     cmd.underload_shutdown_enable && cmd.switches[sw]) begin
          uld_latch[sw] <= 1'b1;
        end else if (clear_now) begin
          uld_latch[sw] <= 1'b0;
        end
      end
      assign next_drive[sw] = cmd.switches[sw] & ~uld_latch[sw] & ~pair_block[sw]
                              & ~sense_sync.supply_under
                              & ~(sense_sync.supply_over & cmd.overvoltage_lockout_enable);
    end
  endgenerate

  // Driver levels start off and only follow the gated commands.
  always_ff @(posedge mclk) begin
    if (srst) begin
      drivers <= '0;
    end else begin
      drivers <= thb_switch_type'(next_drive);
    end
  end

  // Status word assembled from flags and the real driver states.
  always_comb begin
    status_now                      = thb_status_type'(`THB_STATUS_RESET);
    status_now.supply_fail_flag     = supply_fail_flag;
    status_now.underload_flag       = underload_flag;
    status_now.overcurrent_flag     = overcurrent_flag;
    status_now.shoot_through_flag   = shoot_through_flag;
    status_now.switches             = drivers;
    status_now.thermal_warning_flag = thermal_warning_flag;
  end

  // The snapshot follows while deselected and freezes during a frame.
  always_ff @(posedge mclk) begin
    if (srst) begin
      status_hold <= `THB_STATUS_RESET;
    end else if (cs_sync) begin
      status_hold <= status_now;
    end
  end

  // ---------------- Checks ----------------

  AST_OE_DESELECT: assert property (@(posedge mclk) disable iff (srst)
    chip_select_n |-> !serial_out_oe)
    else $error("serial output driven while deselected");

  AST_BAD_LENGTH: assert property (@(posedge mclk) disable iff (srst)
    (cs_rise && bit_count != 4'h0) |=> $stable(cmd))
    else $error("frame of wrong length changed the command");

  AST_GOOD_LATCH: assert property (@(posedge mclk) disable iff (srst)
    frame_ok |=> (cmd.switches == $past(rx_word.switches))
                 && (cmd.overvoltage_lockout_enable == $past(shift_word[`THB_LOCKOUT_BIT])))
    else $error("valid frame not latched");

  AST_IGNORED_BITS: assert property (@(posedge mclk) disable iff (srst)
    frame_ok |=> cmd.unused == '0 ##1 status_hold[11:7] == 5'h00)
    else $error("unused bits not ignored");

  AST_SUPPLY_SET: assert property (@(posedge mclk) disable iff (srst)
    (set_ok && sense_sync.supply_over) |=> supply_fail_flag)
    else $error("supply fail flag missed overvoltage");

  AST_SUPPLY_HOLD: assert property (@(posedge mclk) disable iff (srst)
    (supply_fail_flag && !clear_now) |=> supply_fail_flag)
    else $error("supply fail flag dropped without clear");

  AST_LOCKOUT: assert property (@(posedge mclk) disable iff (srst)
    (sense_sync.supply_over && cmd.overvoltage_lockout_enable) |=> drivers == '0)
    else $error("outputs on during overvoltage lockout");

  AST_RESUME: assert property (@(posedge mclk) disable iff (srst)
    ($fell(sense_sync.supply_over) && $stable(cmd) && set_ok && !shoot_through_flag
     && uld_latch == '0 && !sense_sync.supply_under) |=> drivers == $past(cmd.switches))
    else $error("outputs did not resume after overvoltage");

  AST_UNDERVOLT: assert property (@(posedge mclk) disable iff (srst)
    sense_sync.supply_under |=> drivers == '0)
    else $error("driver on during undervoltage");

  AST_FILTER: assert property (@(posedge mclk) disable iff (srst)
    frame_ok |=> (filt_state == THB_FLT_HOLD)[*8])
    else $error("fault filter not started");

  AST_FIRST_EDGE: assert property (@(posedge sclk) disable iff (srst)
    (!chip_select_n && fresh) |=> bit_count == 4'h1
      && shift_word[`THB_WORD_BITS-2:0] == $past(status_hold[`THB_WORD_BITS-1:1]))
    else $error("first edge did not start the frame");

  COV_GOOD_FRAME: cover property (@(posedge mclk) disable iff (srst) frame_ok);
  COV_BAD_FRAME:  cover property (@(posedge mclk) disable iff (srst)
    cs_rise && bit_count != 4'h0);
  COV_LOCKOUT:    cover property (@(posedge mclk) disable iff (srst)
    sense_sync.supply_over && cmd.overvoltage_lockout_enable && cmd.switches != '0);
  COV_SHOOT:      cover property (@(posedge mclk) disable iff (srst)
    frame_ok && (|rx_conflict));

endmodule // thb_spi_ctrl

// >>> tb/thb_host_model.sv
// Host serial master model for the triple half-bridge control block.
// Assumes one caller at a time; the serial clock moves only inside frames.
`timescale 1ns/1ps

module thb_host_model (
  output logic        sclk,
  output logic        chip_select_n,
  output logic        serial_in,
  input  wire logic   so_wire,
  output logic        frame_done,
  output logic [31:0] rx_data
);
  // Idle levels: deselected, clock low, data at its pull-down level.
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
    frame_done = 1'b0;
    rx_data = 32'h0000_0000;
  end

  // Sends n clocks of tx, bit 0 first, and reads the answer just before each rise.
  task automatic frame(input int n, input logic [31:0] tx);
    rx_data = 32'h0000_0000;
    chip_select_n = 1'b0;
    #150;
    for (int i = 0; i < n; i++) begin
      serial_in = tx[i];
      #7.5;
      rx_data[i] = so_wire;
      sclk = 1'b1;
      #7.5;
      sclk = 1'b0;
    end
    serial_in = 1'b0;
    #100;
    chip_select_n = 1'b1;
    frame_done = 1'b1;
    #1;
    frame_done = 1'b0;
    #5000;
  endtask
endmodule // thb_host_model

// >>> tb/tb.sv
// Self-checking bench for the triple half-bridge serial control block.
// Assumes the design package and the host model are compiled first.
`timescale 1ns/1ps

module tb;
  import thb_pkg::*;

  localparam int unsigned OC_LONG  = 300;
  localparam int unsigned OC_SHORT = 40;

  logic           mclk = 1'b0;
  logic           srst = 1'b1;
  thb_sense_type  sense = '0;
  wire logic      sclk, chip_select_n, serial_in, frame_done, so_wire;
  wire logic [31:0] rx_data;
  logic           serial_out, serial_out_oe, uld_en, ocd_sel;
  logic [14:0]    oc_cycles;
  thb_switch_type drivers, cur, sw;
  logic [31:0]    exp_q[$];
  logic [31:0]    seed_dummy;
  logic [15:0]    w1;
  logic [5:0]     ul_mask;
  int             bad_len[3] = '{0, 15, 17};
  int             n_fail = 0;
  int             samples_checked = 0;

  // The serial output floats when not enabled.
  assign so_wire = serial_out_oe ? serial_out : 1'bz;

  always #5 mclk = ~mclk;

  thb_spi_ctrl #(.OC_LONG_CYCLES(OC_LONG), .OC_SHORT_CYCLES(OC_SHORT)) i_thb_spi_ctrl (
    .mclk(mclk), .srst(srst), .sclk(sclk), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .sense(sense), .drivers(drivers), .underload_shutdown_enable(uld_en),
    .overcurrent_delay_select(ocd_sel), .oc_delay_cycles(oc_cycles));

  thb_host_model i_thb_host_model (
    .sclk(sclk), .chip_select_n(chip_select_n), .serial_in(serial_in),
    .so_wire(so_wire), .frame_done(frame_done), .rx_data(rx_data));

  task automatic tally(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_status(input logic [31:0] exp, input logic [31:0] got);
    tally("status_word", exp, got);
  endtask

  task automatic check_port(input string what, input logic [31:0] exp, input logic [31:0] got);
    tally(what, exp, got);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Status word as the host should read it; unused bits stay zero.
  function automatic logic [15:0] status_of(input logic [3:0] flags, input thb_switch_type s,
                                            input logic tw);
    thb_status_type st;
    st = '0;
    {st.supply_fail_flag, st.underload_flag, st.overcurrent_flag, st.shoot_through_flag} = flags;
    st.switches = s;
    st.thermal_warning_flag = tw;
    return st;
  endfunction

  // Command word with random filler in the ignored bits.
  function automatic logic [15:0] mk_cmd(input logic ov, input logic ul, input logic oc,
                                         input thb_switch_type s, input logic clr);
    thb_cmd_type c;
    c.overvoltage_lockout_enable = ov;
    c.underload_shutdown_enable = ul;
    c.overcurrent_delay_select = oc;
    c.unused = 6'($urandom());
    c.switches = s;
    c.status_clear_request = clr;
    return c;
  endfunction

  // Random switch pattern with at most one side on in each channel.
  function automatic thb_switch_type rand_sw();
    logic [5:0] v;
    for (int c = 0; c < 3; c++) v[2*c +: 2] = 2'($urandom_range(2, 0));
    return thb_switch_type'(v);
  endfunction

  // Notes the expected answer: status first, then the bits sent 16 clocks earlier.
  task automatic send(input int n, input logic [31:0] tx, input logic [15:0] st);
    exp_q.push_back({tx[15:0], st} & ((32'h1 << n) - 32'h1));
    @(negedge mclk);
    i_thb_host_model.frame(n, tx);
  endtask

  // Compares each finished frame with the oldest note.
  always @(posedge frame_done) begin
    if (exp_q.size() == 0) tally("status_queue", 32'h1, 32'h0);
    else check_status(exp_q.pop_front(), rx_data);
  end

  task automatic summarize();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run time.
  initial begin
    #900000;
    n_fail++;
    summarize();
  end

  // Main sequence.
  initial begin
    seed_dummy = $urandom(32'hfda5e8ec);
    cur = '0;
    wait_n(16);
    srst = 1'b0;
    wait_n(4);
    check_port("drivers_reset", 32'h0, drivers);
    check_port("oc_cycles_reset", OC_LONG, oc_cycles);
    check_port("oe_idle", 32'h0, serial_out_oe);
    // Every underload and delay option setting with a fresh switch pattern.
    for (int k = 0; k < 4; k++) begin
      sw = rand_sw();
      send(16, mk_cmd(1'b0, k[0], k[1], sw, 1'b1), status_of(4'h0, cur, 1'b0));
      cur = sw;
      check_port("drivers", cur, drivers);
      check_port("uld_en", k[0], uld_en);
      check_port("ocd_sel", k[1], ocd_sel);
      check_port("oc_cycles", k[1] ? OC_SHORT : OC_LONG, oc_cycles);
    end
    // Frames of wrong length are dropped.
    foreach (bad_len[i]) begin
      send(bad_len[i], mk_cmd(1'b1, 1'b1, 1'b1, rand_sw(), 1'b1),
           status_of(4'h0, cur, 1'b0));
      check_port("drivers_kept", cur, drivers);
    end
    // Two words in one frame: the last one is taken, the first is echoed.
    w1 = mk_cmd(1'b0, 1'b0, 1'b0, rand_sw(), 1'b1);
    sw = rand_sw();
    send(32, {mk_cmd(1'b0, 1'b0, 1'b0, sw, 1'b1), w1}, status_of(4'h0, cur, 1'b0));
    cur = sw;
    check_port("drivers_chain", cur, drivers);
    // Both sides of one channel commanded: refused, reported, then cleared.
    sw = thb_switch_type'(cur | (6'h03 << (2 * $urandom_range(2, 0))));
    send(16, mk_cmd(1'b0, 1'b0, 1'b0, sw, 1'b1), status_of(4'h0, cur, 1'b0));
    check_port("drivers_shoot", 32'h0, drivers);
    send(16, mk_cmd(1'b0, 1'b1, 1'b0, cur, 1'b1), status_of(4'h1, '0, 1'b0));
    check_port("drivers_shoot_clear", cur, drivers);
    // Thermal, overcurrent and underload faults are each latched, reported, then cleared.
    for (int k = 0; k < 3; k++) begin
      wait_n(700);
      ul_mask = (k == 2) ? 6'(6'h01 << $urandom_range(5, 0)) : 6'h00;
      if (k == 0) sense.thermal_warning = 1'b1;
      if (k == 1) sense.overcurrent = 6'h01 << $urandom_range(5, 0);
      if (k == 2) sense.underload = ul_mask;
      wait_n(20);
      sense = '0;
      check_port("drivers_fault", 32'(cur & ~ul_mask), drivers);
      send(16, mk_cmd(1'b0, 1'b1, 1'b0, cur, 1'b1),
           status_of(k == 1 ? 4'h2 : (k == 2 ? 4'h4 : 4'h0),
                     thb_switch_type'(cur & ~ul_mask), k == 0));
      check_port("drivers_flag", cur, drivers);
      send(16, mk_cmd(1'b0, 1'b1, 1'b0, cur, 1'b1), status_of(4'h0, cur, 1'b0));
    end
    // Overvoltage with and without lockout.
    for (int lo = 1; lo >= 0; lo--) begin
      send(16, mk_cmd(lo[0], 1'b0, 1'b0, cur, 1'b1), status_of(4'h0, cur, 1'b0));
      wait_n(700);
      sense.supply_over = 1'b1;
      wait_n(20);
      check_port("drivers_ov", lo ? 32'h0 : 32'(cur), drivers);
      sense.supply_over = 1'b0;
      wait_n(20);
      check_port("drivers_after_ov", cur, drivers);
      send(16, mk_cmd(lo[0], 1'b0, 1'b0, cur, 1'b0), status_of(4'h8, cur, 1'b0));
      send(16, mk_cmd(lo[0], 1'b0, 1'b0, cur, 1'b1), status_of(4'h8, cur, 1'b0));
      send(16, mk_cmd(lo[0], 1'b0, 1'b0, cur, 1'b1), status_of(4'h0, cur, 1'b0));
    end
    // Driver undervoltage keeps drivers off but not the serial port.
    wait_n(700);
    sense.supply_under = 1'b1;
    wait_n(20);
    check_port("drivers_uv", 32'h0, drivers);
    sw = rand_sw();
    send(16, mk_cmd(1'b0, 1'b0, 1'b0, sw, 1'b1), status_of(4'h8, '0, 1'b0));
    check_port("drivers_uv_cmd", 32'h0, drivers);
    sense.supply_under = 1'b0;
    wait_n(20);
    cur = sw;
    check_port("drivers_after_uv", cur, drivers);
    send(16, mk_cmd(1'b0, 1'b0, 1'b0, cur, 1'b1), status_of(4'h0, cur, 1'b0));
    check_port("oe_end", 32'h0, serial_out_oe);
    check_port("queue_left", 32'h0, exp_q.size());
    summarize();
  end
endmodule // tb
